// [core/code_word_cfg.svh]
/*
 * constants of the code word assembler: field positions, widths, reset values, timing counts.
 * assumes a 50 MHz clock and inclusion by bare name.
 */
`ifndef CODE_WORD_CFG_SVH
`define CODE_WORD_CFG_SVH
`define CLK_HZ            50000000
`define SEED_DLY_0_8_MS   800
`define SEED_DLY_1_6_MS   1600
`define SEED_DLY_3_2_MS   3200
`define QUEUE_WIN_MS      2000
`define MS_CYC            (`CLK_HZ / 1000)
`define SEED_TRIP_CNT     20'h0007f
`define FACTORY_STOP_CNT  20'h00080
`define BODY_BITS         7'h41
`define FUNC_SEED         4'hf
`define SYNC_RST          20'h00000
`define OVR_RST           2'h3
`endif

// [core/code_word_pkg.sv]
/*
 * types shared by the code word assembler.
 * assumes nothing of its surroundings.
 */
package code_word_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_GAP   = 2'b10
    } tx_state_t;
endpackage : code_word_pkg

// [core/hopping_code_word_assembler.sv]
/*
 * assembles and serialises hopping and seed code words of a dual-configuration encoder.
 * assumes buttons, select pin and battery comparator arrive asynchronously; cipher outside;
 * configuration registers reached over avalon-mm with waitrequest.
 */
// The implementer's own choices: the address map and the Avalon-MM slave port.
// How it works
// R01: select pin picks configuration one or two
// R02: two configurations, separate serial, key, counter, seed
// R03: hop 32, fixed 32, status bits 3-5
// R04: hop result latched at press, held
// R05: one counter width choice for both
// R06: 16-bit: 10-bit disc, two overflow flags
// R07: 20-bit: 8-bit disc, function fills rest
// R08: fixed holds 28 serial plus function code
// R09: pressed buttons OR into function code
// R10: function bits map inputs 3,0,1,2
// R11: status: battery, crc, queue when enabled
// R12: threshold option chooses detector trip level
// R13: battery flag sent in every word
// R14: hold option keeps battery flag until recovery
// R15: first gap may stretch once, 4 ms
// R16: seed word: 60 fixed bits, function ones
// R17: seed trigger field matches pressed buttons
// R18: seed limit blocks above 127 forever
// R19: seed delay sends hopping words first
// R20: factory mode: min hopping then seed words
// R21: counter advances only on hopping words; the code also steps it on seed words in delay or factory mode
// R22: two crc bits over 65 bits
// R23: saturating queue counter, presses within 2s
// R24: hop, fixed, status, each lsb first
`timescale 1ns/1ps
`include "code_word_cfg.svh"
module hopping_code_word_assembler (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic [3:0]  buttons,
    input  wire logic        encoder_select,
    input  wire logic        low_batt_trip,
    input  wire logic        low_batt_recover,
    input  wire logic [31:0] cipher_result,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [31:0]      cipher_plain,
    output logic             cipher_cfg,
    output logic             cipher_start,
    output logic             serial_data,
    output logic             word_active,
    output logic             threshold_sel,
    output logic             gap_stretch
);
    // ****************************************
    // input synchronisers
    // ****************************************
    logic [6:0] s1_q, s2_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 7'h00;
            s2_q <= 7'h00;
        end else if (clk_en) begin
            s1_q <= {low_batt_recover, low_batt_trip, encoder_select, buttons};
            s2_q <= s1_q;
        end
    end
    wire [3:0] btn      = s2_q[3:0];
    wire       cfg_sel  = s2_q[4];                    // [R01]
    wire       bat_low  = s2_q[5];
    wire       bat_ok   = s2_q[6];

    // ****************************************
    // configuration registers, two banks
    // ****************************************
    // word 0 shared options, 1..6 bank one, 9..14 bank two; offset b = bank*8
    logic [7:0]  shared_q;
    logic [31:0] serial_q [2];
    logic [9:0]  disc_q [2];
    logic [31:0] seed_lo_q [2];
    logic [27:0] seed_hi_q [2];
    logic [15:0] bopt_q [2];
    logic [19:0] sync_q [2];
    logic [1:0]  ovr_q [2];
    logic        seed_off_q [2];
    wire cnt20     = shared_q[0];                    // [R05]
    wire hold_opt  = shared_q[1];
    assign threshold_sel = shared_q[2];              // [R12]
    // bank option bits: 0 full serial, 1 queue, 2 limit, 3 factory, 5:4 delay, 11:8 trigger
    wire [15:0] bo = bopt_q[cfg_sel];                // [R02]
    wire [3:0]  trig = bo[11:8];

    wire bus_req = avs_read | avs_write;
    // a write lands only at the edge where waitrequest is low, as the master sees it
    wire wr_hit  = avs_write & ~avs_waitrequest;
    wire bk      = avs_address[3];
    wire [2:0] ra = avs_address[2:0];
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (avs_address == 4'h0) rd_mux = {24'h000000, shared_q};
        else if (ra == 3'h1) rd_mux = serial_q[bk];
        else if (ra == 3'h2) rd_mux = {22'h000000, disc_q[bk]};
        else if (ra == 3'h3) rd_mux = seed_lo_q[bk];
        else if (ra == 3'h4) rd_mux = {4'h0, seed_hi_q[bk]};
        else if (ra == 3'h5) rd_mux = {16'h0000, bopt_q[bk]};
        else if (ra == 3'h6) rd_mux = {9'h000, seed_off_q[bk], ovr_q[bk], sync_q[bk]};
    end
    // one wait state: request taken on the second edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else if (clk_en) begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (avs_read & avs_waitrequest) avs_readdata <= rd_mux;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shared_q <= 8'h00;
        end else if (clk_en && wr_hit && avs_address == 4'h0) begin
            shared_q <= avs_writedata[7:0];
        end
    end

    // ****************************************
    // press detection and function code
    // ****************************************
    // [R09] [R10] or of pressed buttons in the bit order 3,0,1,2
    wire [3:0] func  = {btn[2], btn[1], btn[0], btn[3]};
    logic       pressed_q;
    wire        press  = (|btn) & ~pressed_q;
    wire        rel    = ~(|btn);
    localparam logic [31:0] QWIN = 32'(`QUEUE_WIN_MS) * 32'(`MS_CYC);
    logic [31:0] since_q, held_q;
    logic [1:0]  queue_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pressed_q <= 1'b0;
            since_q   <= 32'hffffffff;
            held_q    <= 32'h00000000;
            queue_q   <= 2'h0;
        end else if (clk_en) begin
            pressed_q <= |btn;
            if (press) since_q <= 32'h00000000;
            else if (since_q != 32'hffffffff) since_q <= since_q + 32'h1;
            held_q <= press ? 32'h00000000 : held_q + {31'h0, held_q != 32'hffffffff};
            // [R23] saturating count of quick repeats
            if (press) queue_q <= (since_q < QWIN) ? queue_q + {1'b0, queue_q != 2'h3} : 2'h0;
        end
    end

    // ****************************************
    // seed decision
    // ****************************************
    localparam logic [31:0] D1 = 32'(`SEED_DLY_0_8_MS) * 32'(`MS_CYC);
    localparam logic [31:0] D2 = 32'(`SEED_DLY_1_6_MS) * 32'(`MS_CYC);
    localparam logic [31:0] D3 = 32'(`SEED_DLY_3_2_MS) * 32'(`MS_CYC);
    wire [19:0] cnt     = sync_q[cfg_sel];
    wire        bank_off = seed_off_q[cfg_sel];
    wire [31:0] dly = (bo[5:4] == 2'h1) ? D1 : (bo[5:4] == 2'h2) ? D2 :
                      (bo[5:4] == 2'h3) ? D3 : 32'h00000000;
    // [R17] zero field never matches
    wire trig_hit = (trig != 4'h0) && (btn == trig);
    // [R18] [R20] limit latched in seed_off once the counter passes 127
    // a counter loaded past the limit blocks at once, before any step sets the latch
    wire seed_ok  = trig_hit && !((bo[2] | bo[3]) && (bank_off || cnt > `SEED_TRIP_CNT));
    logic [3:0] words_q;
    wire [3:0]  min_words = 4'h1;
    // [R19] [R20] hopping words first, then seed words
    wire want_seed = seed_ok && (bo[3] ? (words_q >= min_words) : (held_q >= dly));

    // ****************************************
    // transmit sequencing
    // ****************************************
    code_word_pkg::tx_state_t st_q;
    logic [68:0] sh_q;
    logic [6:0]  bit_q, len_q;
    logic [1:0]  crc_q;
    logic        lowflag_q, stretched_q, seed_word_q, flag_prev_q;
    logic [31:0] hop_q;
    // [R14] hold keeps flag until the supply recovers
    wire low_now = hold_opt ? (lowflag_q ? ~bat_ok : bat_low) : bat_low;
    // [R06] [R07] plaintext layout by counter width
    assign cipher_cfg = cfg_sel;
    wire [31:0] plain = cnt20 ? {func, disc_q[cfg_sel][7:0], cnt}
                              : {func, ovr_q[cfg_sel], disc_q[cfg_sel], cnt[15:0]};
    // [R08] fixed portion
    wire [31:0] fixed = bo[0] ? serial_q[cfg_sel] : {func, serial_q[cfg_sel][27:0]};
    // [R16] seed body: 60 stored bits and function all ones
    wire [63:0] seed_body = {`FUNC_SEED, seed_hi_q[cfg_sel], seed_lo_q[cfg_sel]};
    // [R03] [R24] hop first, lsb first
    wire [63:0] body = want_seed ? seed_body : {fixed, hop_q};
    wire        last_body = (bit_q == `BODY_BITS - 7'h1);
    wire        in_crc    = (bit_q < `BODY_BITS);
    wire        crc_in    = sh_q[0];
    wire        c1n = crc_q[0] ^ crc_in;               // [R22]
    wire        c0n = c1n ^ crc_q[1];                  // [R22]
    // wait for the cipher answer so the first word already carries the new hop
    wire        start = (st_q == code_word_pkg::ST_IDLE) && (|btn) && !press && !cipher_start;
    wire        advance = start && !want_seed;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q         <= code_word_pkg::ST_IDLE;
            sh_q         <= 69'h0;
            bit_q        <= 7'h00;
            len_q        <= 7'h00;
            crc_q        <= 2'h0;
            lowflag_q    <= 1'b0;
            flag_prev_q  <= 1'b0;
            stretched_q  <= 1'b0;
            seed_word_q  <= 1'b0;
            hop_q        <= 32'h00000000;
            words_q      <= 4'h0;
            cipher_start <= 1'b0;
            cipher_plain <= 32'h00000000;
            serial_data  <= 1'b0;
            word_active  <= 1'b0;
            gap_stretch  <= 1'b0;
        end else if (clk_en) begin
            lowflag_q    <= low_now;
            cipher_start <= press;
            if (press) cipher_plain <= plain;         // [R04]
            if (cipher_start) hop_q <= cipher_result; // [R04] held until next press
            if (rel) words_q <= 4'h0;
            gap_stretch <= 1'b0;
            unique case (st_q)
                code_word_pkg::ST_IDLE: begin
                    if (start) begin
                        // [R11] [R13] battery bit sits right after the body
                        sh_q  <= {queue_q, 2'h0, low_now, body};
                        len_q <= bo[1] ? 7'h45 : 7'h43;
                        bit_q <= 7'h00;
                        crc_q <= 2'h0;
                        seed_word_q <= want_seed;
                        st_q  <= code_word_pkg::ST_SHIFT;
                        // [R15] one stretch when the held flag changes
                        gap_stretch <= hold_opt && (low_now != flag_prev_q) && !stretched_q;
                        if (hold_opt && low_now != flag_prev_q) stretched_q <= 1'b1;
                        flag_prev_q <= low_now;
                    end
                end
                code_word_pkg::ST_SHIFT: begin
                    serial_data <= sh_q[0];
                    word_active <= 1'b1;  // rises with bit 0 so the frame spans only the word
                    sh_q  <= {1'b0, sh_q[68:1]};
                    if (in_crc) crc_q <= {c1n, c0n};
                    if (last_body) sh_q[1:0] <= {c1n, c0n};   // [R22] crc follows 65 bits
                    bit_q <= bit_q + 7'h1;
                    if (bit_q == len_q - 7'h1) st_q <= code_word_pkg::ST_GAP;
                end
                code_word_pkg::ST_GAP: begin
                    serial_data <= 1'b0;
                    word_active <= 1'b0;
                    if (words_q != 4'hf) words_q <= words_q + 4'h1;
                    st_q <= code_word_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // bank registers and counter update
    // ****************************************
    // [R21] counter moves on hopping words; seed words move it under delay or factory mode
    wire cnt_step = start && (!want_seed || bo[3] || bo[5:4] != 2'h0);
    for (genvar b = 0; b < 2; b++) begin : g_bank
        wire sel_b = (cfg_sel == 1'(b));
        wire wr_b  = wr_hit && (bk == 1'(b));
        wire [20:0] nxt = {1'b0, sync_q[b]} + 21'h1;
        wire wrap  = cnt20 ? nxt[20] : nxt[16];
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                serial_q[b]   <= 32'h00000000;
                disc_q[b]     <= 10'h000;
                seed_lo_q[b]  <= 32'h00000000;
                seed_hi_q[b]  <= 28'h0000000;
                bopt_q[b]     <= 16'h0000;
                sync_q[b]     <= `SYNC_RST;
                ovr_q[b]      <= `OVR_RST;
                seed_off_q[b] <= 1'b0;
            end else if (clk_en) begin
                if (wr_b && ra == 3'h1) serial_q[b]  <= avs_writedata;
                if (wr_b && ra == 3'h2) disc_q[b]    <= avs_writedata[9:0];
                if (wr_b && ra == 3'h3) seed_lo_q[b] <= avs_writedata;
                if (wr_b && ra == 3'h4) seed_hi_q[b] <= avs_writedata[27:0];
                if (wr_b && ra == 3'h5) bopt_q[b]    <= avs_writedata[15:0];
                if (wr_b && ra == 3'h6) begin
                    sync_q[b]     <= avs_writedata[19:0];
                    ovr_q[b]      <= avs_writedata[21:20];
                    seed_off_q[b] <= avs_writedata[22];
                end else if (sel_b && cnt_step) begin
                    sync_q[b] <= cnt20 ? nxt[19:0] : {4'h0, nxt[15:0]};
                    // [R06] first wrap clears the first flag, second the second
                    if (!cnt20 && wrap) ovr_q[b] <= ovr_q[b][0] ? {ovr_q[b][1], 1'b0} : 2'h0;
                    // [R18] sticky block survives counter wrap
                    if (nxt[19:0] > `SEED_TRIP_CNT) seed_off_q[b] <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    crc_order_a: assert property (@(posedge clk) disable iff (rst)   // [R22]
        (clk_en && st_q == code_word_pkg::ST_SHIFT && bit_q == 7'h00) |-> crc_q == 2'h0)
        else $error("crc not cleared at word start");
    seed_block_a: assert property (@(posedge clk) disable iff (rst)  // [R18]
        (bo[2] && bank_off && !bo[3]) |-> !want_seed)
        else $error("seed allowed past limit");
    trig_zero_a: assert property (@(posedge clk) disable iff (rst)   // [R17]
        (trig == 4'h0) |-> !want_seed)
        else $error("seed with empty trigger");
    hop_hold_a: assert property (@(posedge clk) disable iff (rst)    // [R04]
        (clk_en && !cipher_start) |=> $stable(hop_q))
        else $error("hop changed without press");
    word_len_a: assert property (@(posedge clk) disable iff (rst)    // [R03]
        (st_q == code_word_pkg::ST_SHIFT) |-> (len_q == 7'h43 || len_q == 7'h45))
        else $error("bad word length");
    cnt_seed_a: assert property (@(posedge clk) disable iff (rst)    // [R21]
        (clk_en && start && want_seed && !bo[3] && bo[5:4] == 2'h0 && !wr_hit)
        |=> $stable(sync_q[cfg_sel]))
        else $error("counter moved on seed word");
    queue_sat_a: assert property (@(posedge clk) disable iff (rst)   // [R23]
        (clk_en && queue_q == 2'h3 && press && since_q < QWIN) |=> queue_q == 2'h3)
        else $error("queue counter wrapped");
    func_map_a: assert property (@(posedge clk) disable iff (rst)    // [R10]
        btn == 4'h8 |-> func == 4'h1)
        else $error("button three not mapped to bit zero");
    // limits and word layout: these catch a loaded counter and a misplaced field
    seed_cnt_a: assert property (@(posedge clk) disable iff (rst)    // [R18]
        (bo[2] && cnt > `SEED_TRIP_CNT) |-> !want_seed)
        else $error("seed allowed with counter past limit");
    factory_stop_a: assert property (@(posedge clk) disable iff (rst) // [R20]
        (bo[3] && cnt >= `FACTORY_STOP_CNT) |-> !want_seed)
        else $error("factory seed past stop count");
    word_gap_a: assert property (@(posedge clk) disable iff (rst)    // [R24]
        (clk_en && st_q == code_word_pkg::ST_GAP) |=> !word_active)
        else $error("frame not closed after word");
    stretch_once_a: assert property (@(posedge clk) disable iff (rst) // [R15]
        (clk_en && gap_stretch) |-> stretched_q)
        else $error("stretch without latch");
    fixed_func_a: assert property (@(posedge clk) disable iff (rst)  // [R08]
        (!bo[0]) |-> fixed[31:28] == func)
        else $error("fixed part lacks function copy");
    seed_func_a: assert property (@(posedge clk) disable iff (rst)   // [R16]
        want_seed |-> body[63:60] == `FUNC_SEED)
        else $error("seed word function not all ones");
    cnt_hop_a: assert property (@(posedge clk) disable iff (rst)     // [R21]
        advance |-> cnt_step)
        else $error("hopping word without counter step");
    disc_short_a: assert property (@(posedge clk) disable iff (rst)  // [R07]
        cnt20 |-> plain[27:20] == disc_q[cfg_sel][7:0])
        else $error("short discrimination misplaced");
    queue_clr_a: assert property (@(posedge clk) disable iff (rst)   // [R23]
        (clk_en && press && since_q >= QWIN) |=> queue_q == 2'h0)
        else $error("queue not cleared after slow press");
    crc_load_a: assert property (@(posedge clk) disable iff (rst)    // [R22]
        (clk_en && st_q == code_word_pkg::ST_SHIFT && last_body) |=> sh_q[1:0] == crc_q)
        else $error("crc not placed after body");
    batt_bit_a: assert property (@(posedge clk) disable iff (rst)    // [R13]
        (clk_en && start) |=> sh_q[64] == lowflag_q)
        else $error("battery bit not loaded");
    word_size_a: assert property (@(posedge clk) disable iff (rst)   // [R11]
        (clk_en && start) |=> len_q == (bo[1] ? 7'h45 : 7'h43))
        else $error("length ignores queue option");
endmodule : hopping_code_word_assembler

// [test/rf_decoder_model.sv]
/*
 * receiving end of the serial code word link: gathers each word bit by bit.
 * assumes word_active frames a word and one bit arrives per clock while it is high.
 */
`timescale 1ns/1ps
module rf_decoder_model (
    input wire logic clk,
    input wire logic serial_data,
    input wire logic word_active
);
    // ****************************************************************
    // word capture
    // ****************************************************************
    logic [68:0] bits_q = '0;
    logic [68:0] last_bits = '0;
    int          n_q = 0;
    int          last_len = 0;
    int          words = 0;

    // bit i is the i-th bit heard, so every field reads lsb first
    always @(posedge clk) begin
        if (word_active === 1'b1) begin
            if (n_q < 69) bits_q[n_q] <= serial_data;
            n_q <= n_q + 1;
        end else if (n_q != 0) begin
            last_bits <= bits_q;
            last_len <= n_q;
            words <= words + 1;
            bits_q <= '0; // cleared so a short word leaves no stale queue bits
            n_q <= 0;
        end
    end
endmodule : rf_decoder_model

// [test/test_hopping_code_word_assembler.sv]
/*
 * self-checking bench of the code word assembler: bus setup, presses, word checks.
 * assumes rf_decoder_model listens at the serial output; the cipher is a random level.
 */
`timescale 1ns/1ps
module test_hopping_code_word_assembler;
    // ****************************************************************
    // stimulus and bookkeeping
    // ****************************************************************
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  buttons = 4'h0;
    logic        encoder_select = 1'b0;
    logic        low_batt_trip = 1'b0;
    logic        low_batt_recover = 1'b0;
    logic [31:0] cipher_result = 32'h0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    wire  [31:0] avs_readdata, cipher_plain;
    wire         avs_waitrequest, cipher_cfg, cipher_start, serial_data, word_active;
    wire         threshold_sel, gap_stretch;
    int          failures = 0, checked = 0, cycles = 0;
    logic [31:0] rd, hop, serial_number_value [2];
    logic [9:0]  disc [2];
    logic [59:0] seed [2];
    logic [19:0] cnt [2];
    logic        w20 = 1'b0, full = 1'b0, qen = 1'b0, bat = 1'b0;

    hopping_code_word_assembler dut (.clk(clk), .rst(rst), .clk_en(1'b1), .buttons(buttons),
        .encoder_select(encoder_select), .low_batt_trip(low_batt_trip),
        .low_batt_recover(low_batt_recover), .cipher_result(cipher_result),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cipher_plain(cipher_plain),
        .cipher_cfg(cipher_cfg), .cipher_start(cipher_start), .serial_data(serial_data),
        .word_active(word_active), .threshold_sel(threshold_sel), .gap_stretch(gap_stretch));
    rf_decoder_model rx (.clk(clk), .serial_data(serial_data), .word_active(word_active));

    // clock and a cycle ceiling well above the sixteen presses
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            finish_test();
        end
    end

    task finish_test;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task chk(input logic [68:0] got, input logic [68:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one avalon transfer; holds the request until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    // two check bits over hop, fixed and battery bits
    function automatic logic [68:0] word(logic [63:0] body, logic b, logic [1:0] q);
        logic [64:0] v;
        logic [1:0]  c;
        v = {b, body};
        c = 2'h0;
        for (int i = 0; i < 65; i++) c = {c[0] ^ v[i], c[0] ^ v[i] ^ c[1]};
        return {q, c, v};
    endfunction : word

    // buttons held until the word starts, so exactly one word follows
    task press(input logic [3:0] b);
        int n, t;
        n = rx.words;
        t = 0;
        hop = $urandom;
        cipher_result <= hop;
        buttons <= b;
        while (word_active !== 1'b1 && t < 300) begin
            @(posedge clk);
            t++;
        end
        buttons <= 4'h0;
        while (rx.words == n && t < 600) begin
            @(posedge clk);
            t++;
        end
        repeat (4) @(posedge clk);
    endtask : press

    task run(input logic k, input logic [3:0] b, input logic sd, input logic [1:0] q);
        logic [3:0]  f;
        logic [63:0] body;
        logic [31:0] pl;
        f = {b[2], b[1], b[0], b[3]};
        encoder_select <= k;
        repeat (3) @(posedge clk);
        press(b);
        body = sd ? {4'hf, seed[k]} : {full ? serial_number_value[k] : {f, serial_number_value[k][27:0]}, hop};
        pl = w20 ? {f, disc[k][7:0], cnt[k]} : {f, 2'h3, disc[k], cnt[k][15:0]};
        chk(cipher_cfg, k);
        chk(rx.last_len, qen ? 69 : 67);
        chk(rx.last_bits, word(body, bat, q));
        if (!sd) chk(cipher_plain, pl);
        if (!sd) cnt[k] = cnt[k] + 20'h1;
        bus(1'b0, {k, 3'h6}, 32'h0);
        chk(rd[19:0], cnt[k]);
    endtask : run

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h652d));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, 4'h6, 32'h0);
        chk(rd, 32'h0030_0000);
        bus(1'b1, 4'h7, 32'hffff_ffff);
        bus(1'b0, 4'h7, 32'h0);
        chk(rd, 32'h0);
        for (int k = 0; k < 2; k++) begin
            serial_number_value[k] = $urandom;
            disc[k] = 10'($urandom);
            seed[k] = {28'($urandom), 32'($urandom)};
            cnt[k] = 20'h0;
            bus(1'b1, 4'(8 * k + 1), serial_number_value[k]);
            bus(1'b1, 4'(8 * k + 2), {22'h0, disc[k]});
            bus(1'b1, 4'(8 * k + 3), seed[k][31:0]);
            bus(1'b1, 4'(8 * k + 4), {4'h0, seed[k][59:32]});
        end
        // repeat presses well inside the window: count climbs and sticks at 3
        bus(1'b1, 4'h5, 32'h2);
        qen = 1'b1;
        for (int i = 0; i < 5; i++) run(1'b0, 4'($urandom_range(15, 1)), 1'b0, 2'(i > 3 ? 3 : i));
        bus(1'b1, 4'h5, 32'h0);
        qen = 1'b0;
        // each single button, both counter widths, second bank with the full serial
        bus(1'b1, 4'hd, 32'h1);
        for (int k = 0; k < 4; k++) begin
            w20 = k[1];
            full = k[0];
            bat = (k == 2);
            low_batt_trip <= bat;
            bus(1'b1, 4'h0, {29'h0, w20, 1'b0, w20});
            chk(threshold_sel, w20);
            run(k[0], 4'h1 << k, 1'b0, 2'h0);
        end
        full = 1'b0;
        w20 = 1'b0;
        // held battery flag: trip, hold with trip gone, clear on recovery
        bus(1'b1, 4'h0, 32'h2);
        for (int k = 0; k < 3; k++) begin
            low_batt_trip <= (k == 0);
            low_batt_recover <= (k == 2);
            bat = (k < 2);
            run(1'b0, 4'h2, 1'b0, 2'h0);
        end
        low_batt_recover <= 1'b0;
        // seed on buttons 0 and 2 with the count limit; blocked past 127, also after the counter is written back to 0
        bus(1'b1, 4'h5, 32'h504);
        run(1'b0, 4'h5, 1'b1, 2'h0);
        run(1'b0, 4'h4, 1'b0, 2'h0);
        bus(1'b0, 4'h6, 32'h0);
        bus(1'b1, 4'h6, {rd[31:20], 20'h80});
        cnt[0] = 20'h80;
        run(1'b0, 4'h5, 1'b0, 2'h0);
        bus(1'b0, 4'h6, 32'h0);
        bus(1'b1, 4'h6, {rd[31:20], 20'h0});
        cnt[0] = 20'h0;
        run(1'b0, 4'h5, 1'b0, 2'h0);
        finish_test();
    end
endmodule : test_hopping_code_word_assembler
